// ===== src/ewp_pkg.sv
// Purpose: Shared constants and types for the configuration word loader.
// Assumes: Three ports, 16-bit memory words, 32-bit configuration registers.
// Notes:   Register access uses {port, byte offset} addressing.
package ewp_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int unsigned NUM_PORTS  = 3;
  localparam int unsigned NUM_SLOTS  = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned MADDR_W    = 8;
  localparam int unsigned CADDR_W    = 12;
  localparam int unsigned OFS_W      = 10;

  // --------------------------------------------------------------------
  // Configuration register byte offsets within one port
  // --------------------------------------------------------------------
  localparam logic [9:0] OFS_TIMERS    = 10'h070;
  localparam logic [9:0] OFS_PM_CTL    = 10'h074;
  localparam logic [9:0] OFS_LTW3      = 10'h080;
  localparam logic [9:0] OFS_LTW5      = 10'h088;
  localparam logic [9:0] OFS_TS_CTL    = 10'h08C;
  localparam logic [9:0] OFS_SLOT_CAP  = 10'h0D4;
  localparam logic [9:0] OFS_VC1_SLOT  = 10'h15C;
  localparam logic [9:0] OFS_TC_MAP    = 10'h160;

  // --------------------------------------------------------------------
  // Storage slot indices
  // --------------------------------------------------------------------
  localparam logic [2:0] SLOT_TIMERS   = 3'h0;
  localparam logic [2:0] SLOT_PM_CTL   = 3'h1;
  localparam logic [2:0] SLOT_LTW3     = 3'h2;
  localparam logic [2:0] SLOT_LTW5     = 3'h3;
  localparam logic [2:0] SLOT_TS_CTL   = 3'h4;
  localparam logic [2:0] SLOT_SLOT_CAP = 3'h5;
  localparam logic [2:0] SLOT_VC1_SLOT = 3'h6;
  localparam logic [2:0] SLOT_TC_MAP   = 3'h7;

  // --------------------------------------------------------------------
  // Memory word address groups (upper nibble)
  // --------------------------------------------------------------------
  localparam logic [3:0] GRP_PM        = 4'h8;
  localparam logic [3:0] GRP_CAP_LO    = 4'h9;
  localparam logic [3:0] GRP_CAP_HI    = 4'hA;
  localparam logic [3:0] GRP_LTW3_LO   = 4'hB;
  localparam logic [3:0] GRP_LTW3_HI   = 4'hC;
  localparam logic [3:0] GRP_REPLAY    = 4'hD;
  localparam logic [3:0] GRP_ACK       = 4'hE;
  localparam logic [3:0] GRP_VC1       = 4'hF;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int unsigned PM_LINK_LSB   = 8;
  localparam int unsigned PM_LINK_MSB   = 13;
  localparam int unsigned PM_RXPOL_BIT  = 14;
  localparam int unsigned VGA_BIT       = 31;
  localparam int unsigned REPLAY_MSB    = 12;
  localparam int unsigned ACK_LSB       = 16;
  localparam int unsigned ACK_MSB       = 30;
  localparam int unsigned TS_LSB        = 24;
  localparam int unsigned TS_MSB        = 25;
  localparam int unsigned VC1_LSB       = 16;
  localparam int unsigned VC1_MSB       = 22;
  localparam int unsigned LTW5_LSB      = 24;

  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam logic [1:0]  PORT_NONE     = 2'h3;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic               valid;
    logic [7:0]         addr;
    logic [15:0]        data;
  } ewp_word_t;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [11:0]        addr;
    logic [31:0]        wdata;
  } ewp_cfg_req_t;

endpackage : ewp_pkg

// ===== src/ewp_loader.sv
// Purpose: Scatters configuration memory words into per-port register fields.
// Assumes: Words arrive one per strobe from a memory reader on the same clock.
// Notes:   Software access opens only after the reader reports the load done.
//
// Function
// - Word 82h bits 5..0 to port1 74h[13:8]
// - PM word bit 6 to 74h[14]
// - PM word bit 7 to 70h[31]
// - PM word bits 15..8 to 88h[31:24]
// - Word 84h is port 2 PM word
// - Words 92h/94h to D4h low half
// - Words A2h/A4h to D4h high half
// - Words B0h..B4h to 80h low half
// - Words C0h..C4h to 80h high half
// - Words D0h..D4h bits 12..0 to 70h[12:0]
// - Same words bits 14..13 to 8Ch[25:24]
// - Words E0h..E4h to 70h[30:16]
// - Words F0h..F4h bits 6..0 to 15Ch[22:16]
// - Same words bits 15..8 to 160h[7:0]
`timescale 1ns/1ps
module ewp_loader (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire ewp_pkg::ewp_word_t   mem_word,
  input  wire logic                 mem_load_done,
  input  wire ewp_pkg::ewp_cfg_req_t cfg_req,
  output logic [31:0]               cfg_rdata_q,
  output logic                      cfg_rvalid_q,
  output logic                      cfg_ready_q
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    EWP_LOADING = 2'b01,
    EWP_READY   = 2'b10
  } ewp_state_t;

  ewp_state_t  state_q;
  logic [31:0] regs_q [ewp_pkg::NUM_PORTS][ewp_pkg::NUM_SLOTS];

  logic [3:0]  grp;
  logic [1:0]  wport;
  logic        wlegal;
  logic [15:0] wd;
  logic        load_en;
  logic [1:0]  cport;
  logic [2:0]  cslot;
  logic        chit;

  // ------------------------------------------------------------------
  // Word decode
  // ------------------------------------------------------------------
  // Low nibble 0, 2 or 4 selects port 0, 1 or 2; any other is dropped.
  assign grp     = mem_word.addr[7:4];
  assign wport   = mem_word.addr[2:1];
  assign wlegal  = (mem_word.addr[3] == 1'b0) && (mem_word.addr[0] == 1'b0)
                   && (wport != ewp_pkg::PORT_NONE);
  assign wd      = mem_word.data;
  assign load_en = mem_word.valid && wlegal && (state_q == EWP_LOADING);

  // ------------------------------------------------------------------
  // Configuration address decode
  // ------------------------------------------------------------------
  assign cport = cfg_req.addr[11:10];

  always_comb begin
    chit  = 1'b1;
    cslot = ewp_pkg::SLOT_TIMERS;
    case (cfg_req.addr[9:0])
      ewp_pkg::OFS_TIMERS:   cslot = ewp_pkg::SLOT_TIMERS;
      ewp_pkg::OFS_PM_CTL:   cslot = ewp_pkg::SLOT_PM_CTL;
      ewp_pkg::OFS_LTW3:     cslot = ewp_pkg::SLOT_LTW3;
      ewp_pkg::OFS_LTW5:     cslot = ewp_pkg::SLOT_LTW5;
      ewp_pkg::OFS_TS_CTL:   cslot = ewp_pkg::SLOT_TS_CTL;
      ewp_pkg::OFS_SLOT_CAP: cslot = ewp_pkg::SLOT_SLOT_CAP;
      ewp_pkg::OFS_VC1_SLOT: cslot = ewp_pkg::SLOT_VC1_SLOT;
      ewp_pkg::OFS_TC_MAP:   cslot = ewp_pkg::SLOT_TC_MAP;
      default:               chit  = 1'b0;
    endcase
    if (cport == ewp_pkg::PORT_NONE) begin
      chit = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Load sequencing
  // ------------------------------------------------------------------
  // Gate on load done.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= EWP_LOADING;
    end else begin
      case (state_q)
        EWP_LOADING: begin
          if (mem_load_done) begin
            state_q <= EWP_READY;
          end
        end
        EWP_READY: state_q <= EWP_READY;
        default:   state_q <= EWP_LOADING;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_ready_q <= 1'b0;
    end else begin
      cfg_ready_q <= (state_q == EWP_READY);
    end
  end

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  // Software writes are whole words; the loader touches only its fields,
  // so the two never meet because writes wait for the ready state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int p = 0; p < ewp_pkg::NUM_PORTS; p++) begin
        for (int s = 0; s < ewp_pkg::NUM_SLOTS; s++) begin
          regs_q[p][s] <= ewp_pkg::REG_RESET;
        end
      end
    end else if (load_en) begin
      case (grp)
        ewp_pkg::GRP_PM: begin
          if (wport != 2'h0) begin
            regs_q[wport][ewp_pkg::SLOT_PM_CTL][13:8] <= wd[5:0];
            regs_q[wport][ewp_pkg::SLOT_PM_CTL][14] <= wd[6];
            regs_q[wport][ewp_pkg::SLOT_TIMERS][31] <= wd[7];
            regs_q[wport][ewp_pkg::SLOT_LTW5][31:24] <= wd[15:8];
          end
        end
        ewp_pkg::GRP_CAP_LO: begin
          if (wport != 2'h0) begin
            regs_q[wport][ewp_pkg::SLOT_SLOT_CAP][15:0] <= wd;
          end
        end
        ewp_pkg::GRP_CAP_HI: begin
          if (wport != 2'h0) begin
            regs_q[wport][ewp_pkg::SLOT_SLOT_CAP][31:16] <= wd;
          end
        end
        ewp_pkg::GRP_LTW3_LO: regs_q[wport][ewp_pkg::SLOT_LTW3][15:0] <= wd;
        ewp_pkg::GRP_LTW3_HI: regs_q[wport][ewp_pkg::SLOT_LTW3][31:16] <= wd;
        ewp_pkg::GRP_REPLAY: begin
          regs_q[wport][ewp_pkg::SLOT_TIMERS][12:0] <= wd[12:0];
          regs_q[wport][ewp_pkg::SLOT_TS_CTL][25:24] <= wd[14:13];
        end
        ewp_pkg::GRP_ACK: regs_q[wport][ewp_pkg::SLOT_TIMERS][30:16] <= wd[14:0];
        ewp_pkg::GRP_VC1: begin
          regs_q[wport][ewp_pkg::SLOT_VC1_SLOT][22:16] <= wd[6:0];
          regs_q[wport][ewp_pkg::SLOT_TC_MAP][7:0] <= wd[15:8];
        end
        default: ;
      endcase
    end else if (cfg_req.wr && chit && (state_q == EWP_READY)) begin
      regs_q[cport][cslot] <= cfg_req.wdata;
    end
  end

  // ------------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------------
  // No answer while loading.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_rdata_q  <= ewp_pkg::REG_RESET;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_req.rd && (state_q == EWP_READY);
      if (cfg_req.rd && chit && (state_q == EWP_READY)) begin
        cfg_rdata_q <= regs_q[cport][cslot];
      end else begin
        cfg_rdata_q <= ewp_pkg::REG_RESET;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking ck @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_word(logic [7:0] a);
    mem_word.valid && (mem_word.addr == a) && (state_q == EWP_LOADING);
  endsequence

  AST_PM_LINK: assert property (s_word(8'h82) |=>
    regs_q[1][ewp_pkg::SLOT_PM_CTL][13:8] == $past(mem_word.data[5:0]))
    else $error("Port 1 link PM field not loaded.");

  AST_RXPOL: assert property (s_word(8'h84) |=>
    regs_q[2][ewp_pkg::SLOT_PM_CTL][14] == $past(mem_word.data[6]))
    else $error("Port 2 polarity bit not loaded.");

  AST_VGA: assert property (s_word(8'h82) |=>
    regs_q[1][ewp_pkg::SLOT_TIMERS][31] == $past(mem_word.data[7]))
    else $error("Port 1 VGA bit not loaded.");

  AST_LTW5: assert property (s_word(8'h84) |=>
    regs_q[2][ewp_pkg::SLOT_LTW5][31:24] == $past(mem_word.data[15:8]))
    else $error("Port 2 tuning word 5 not loaded.");

  AST_CAP: assert property (s_word(8'hA4) |=>
    regs_q[2][ewp_pkg::SLOT_SLOT_CAP][31:16] == $past(mem_word.data)
    && $stable(regs_q[2][ewp_pkg::SLOT_SLOT_CAP][15:0]))
    else $error("Port 2 slot cap high not loaded.");

  AST_LTW3: assert property (s_word(8'hB0) |=>
    regs_q[0][ewp_pkg::SLOT_LTW3][15:0] == $past(mem_word.data))
    else $error("Port 0 tuning word 3 low not loaded.");

  AST_REPLAY: assert property (s_word(8'hD2) |=>
    regs_q[1][ewp_pkg::SLOT_TIMERS][12:0] == $past(mem_word.data[12:0])
    && regs_q[1][ewp_pkg::SLOT_TS_CTL][25:24] == $past(mem_word.data[14:13]))
    else $error("Port 1 replay or training field not loaded.");

  AST_ACK: assert property (s_word(8'hE4) |=>
    regs_q[2][ewp_pkg::SLOT_TIMERS][30:16] == $past(mem_word.data[14:0])
    && $stable(regs_q[2][ewp_pkg::SLOT_TIMERS][12:0]))
    else $error("Port 2 ack timer not loaded or neighbours changed.");

  AST_VC1: assert property (s_word(8'hF2) |=>
    regs_q[1][ewp_pkg::SLOT_TC_MAP][7:0] == $past(mem_word.data[15:8])
    && regs_q[1][ewp_pkg::SLOT_VC1_SLOT][22:16] == $past(mem_word.data[6:0]))
    else $error("Port 1 VC1 fields not loaded.");

  AST_KEEP: assert property (s_word(8'hC0) |=>
    $stable(regs_q[0][ewp_pkg::SLOT_LTW3][15:0]))
    else $error("Tuning word 3 low half disturbed.");

  AST_NO_EARLY: assert property (cfg_rvalid_q |->
    $past(state_q) == EWP_READY && $past(cfg_req.rd))
    else $error("Read answered before load finished.");

endmodule : ewp_loader

// ===== bench/ewp_mem_model.sv
// Purpose: Behavioural configuration memory reader that streams words to the loader.
// Assumes: Word content is a fixed function of its address, known to the bench.
// Notes:   A gap of idle cycles between words models a slow memory.
`timescale 1ns/1ps
module ewp_mem_model (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [1:0]    gap,
  output ewp_pkg::ewp_word_t mem_word,
  output logic               mem_load_done
);
  // ------------------------------------------------------------------
  // Word table
  // ------------------------------------------------------------------
  // Port 0 PM word 80h and low-nibble-6 word 86h are included on purpose; they must be ignored.
  localparam logic [7:0] SEQ [23] = '{8'h80, 8'h82, 8'h84, 8'h92, 8'h94, 8'hA2, 8'hA4,
    8'hB0, 8'hB2, 8'hB4, 8'hC0, 8'hC2, 8'hC4, 8'hD0, 8'hD2, 8'hD4, 8'hE0, 8'hE2,
    8'hE4, 8'hF0, 8'hF2, 8'hF4, 8'h86};
  logic [4:0] idx;
  logic [1:0] pause;
  logic       busy;

  function automatic logic [15:0] wd(input logic [7:0] a);
    return {a, a ^ 8'hA5};
  endfunction : wd

  // ------------------------------------------------------------------
  // Streaming
  // ------------------------------------------------------------------
  // Idle data toggles so a stale word is never mistaken for a fresh one.
  always @(posedge clk) begin
    if (!rst_b) begin
      idx           <= 5'h00;
      pause         <= 2'h0;
      busy          <= 1'b0;
      mem_load_done <= 1'b0;
      mem_word      <= '0;
    end else begin
      mem_word.valid <= 1'b0;
      mem_word.data  <= ~mem_word.data;
      if (start && !busy && !mem_load_done) begin
        busy <= 1'b1;
      end else if (busy && pause != 2'h0) begin
        pause <= pause - 2'h1;
      end else if (busy && idx == 5'd23) begin
        busy          <= 1'b0;
        mem_load_done <= 1'b1;
      end else if (busy) begin
        mem_word <= '{valid: 1'b1, addr: SEQ[idx], data: wd(SEQ[idx])};
        idx      <= idx + 5'h01;
        pause    <= gap;
      end
    end
  end
endmodule : ewp_mem_model

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the configuration word loader.
// Assumes: Memory model streams every mapped word once after each start.
// Notes:   Expected register images are rebuilt here from the word pattern.
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic                  clk     = 1'b0;
  logic                  rst_b   = 1'b0;
  logic                  start   = 1'b0;
  logic [1:0]            gap     = 2'h0;
  ewp_pkg::ewp_word_t    mem_word;
  logic                  mem_load_done;
  ewp_pkg::ewp_cfg_req_t cfg_req = '0;
  logic [31:0]           cfg_rdata_q;
  logic                  cfg_rvalid_q;
  logic                  cfg_ready_q;
  int                    errors  = 0;
  int                    checked = 0;
  int                    cycles  = 0;
  localparam logic [9:0] OFS [8] = '{ewp_pkg::OFS_TIMERS, ewp_pkg::OFS_PM_CTL,
    ewp_pkg::OFS_LTW3, ewp_pkg::OFS_LTW5, ewp_pkg::OFS_TS_CTL, ewp_pkg::OFS_SLOT_CAP,
    ewp_pkg::OFS_VC1_SLOT, ewp_pkg::OFS_TC_MAP};

  always #50 clk = ~clk;

  ewp_mem_model mem (.clk(clk), .rst_b(rst_b), .start(start), .gap(gap),
                     .mem_word(mem_word), .mem_load_done(mem_load_done));
  ewp_loader uut (.clk(clk), .rst_b(rst_b), .mem_word(mem_word),
                  .mem_load_done(mem_load_done), .cfg_req(cfg_req),
                  .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
                  .cfg_ready_q(cfg_ready_q));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] pw(input logic [7:0] base, input int p);
    logic [7:0] a;
    a = base + 8'(2 * p);
    return {a, a ^ 8'hA5};
  endfunction : pw

  function automatic logic [31:0] exp_reg(input int p, input logic [9:0] o);
    logic [15:0] pm, rp, ak, vc;
    pm = (p == 0) ? 16'h0000 : pw(8'h80, p);
    rp = pw(8'hD0, p);
    ak = pw(8'hE0, p);
    vc = pw(8'hF0, p);
    if (p == 3) return 32'h0000_0000;
    case (o)
      ewp_pkg::OFS_TIMERS:   return {pm[7], ak[14:0], 3'h0, rp[12:0]};
      ewp_pkg::OFS_PM_CTL:   return {17'h00000, pm[6:0], 8'h00};
      ewp_pkg::OFS_LTW3:     return {pw(8'hC0, p), pw(8'hB0, p)};
      ewp_pkg::OFS_LTW5:     return {pm[15:8], 24'h000000};
      ewp_pkg::OFS_TS_CTL:   return {6'h00, rp[14:13], 24'h000000};
      ewp_pkg::OFS_SLOT_CAP: return (p == 0) ? 32'h0 : {pw(8'hA0, p), pw(8'h90, p)};
      ewp_pkg::OFS_VC1_SLOT: return {9'h000, vc[6:0], 16'h0000};
      ewp_pkg::OFS_TC_MAP:   return {24'h000000, vc[15:8]};
      default:               return 32'h0000_0000;
    endcase
  endfunction : exp_reg

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [1:0] p, input logic [9:0] o, input logic [31:0] d);
    @(posedge clk);
    cfg_req.wr    <= 1'b1;
    cfg_req.addr  <= {p, o};
    cfg_req.wdata <= d;
    @(posedge clk);
    cfg_req.wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] p, input logic [9:0] o,
                        output logic [31:0] d, output logic v);
    @(posedge clk);
    cfg_req.rd   <= 1'b1;
    cfg_req.addr <= {p, o};
    @(posedge clk);
    cfg_req.rd   <= 1'b0;
    #1;
    d = cfg_rdata_q;
    v = cfg_rvalid_q;
  endtask : rd_reg

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Load with a given pace, then read every register of every port.
  task automatic test_load(input logic [1:0] g);
    logic [31:0] d;
    logic        v;
    int          n;
    rst_b <= 1'b0;
    gap   <= g;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("ready during load", {31'h0, cfg_ready_q}, 32'h0);
    rd_reg(2'h1, ewp_pkg::OFS_TIMERS, d, v);
    chk("read answer during load", {31'h0, v}, 32'h0);
    wr_reg(2'h1, ewp_pkg::OFS_TIMERS, 32'hFFFF_FFFF);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (cfg_ready_q !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("ready after load", {31'h0, cfg_ready_q}, 32'h1);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        rd_reg(2'(p), OFS[k], d, v);
        chk("read valid", {31'h0, v}, 32'h1);
        chk("register image", d, exp_reg(p, OFS[k]));
      end
    end
    $display("test load with gap %0d done", g);
  endtask : test_load

  // Software writes back to back with reads, plus an unmapped offset.
  task automatic test_write();
    logic [31:0] d;
    logic        v;
    wr_reg(2'h0, ewp_pkg::OFS_PM_CTL, 32'h1234_ABCD);
    rd_reg(2'h0, ewp_pkg::OFS_PM_CTL, d, v);
    chk("written register", d, 32'h1234_ABCD);
    rd_reg(2'h2, ewp_pkg::OFS_LTW3, d, v);
    chk("neighbour register", d, exp_reg(2, ewp_pkg::OFS_LTW3));
    wr_reg(2'h1, 10'h004, 32'hFFFF_FFFF);
    rd_reg(2'h1, 10'h004, d, v);
    chk("unmapped read", d, 32'h0);
    $display("test write done");
  endtask : test_write

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    test_load(2'h2);
    test_write();
    test_load(2'h0);
    stop_test();
  end
endmodule : tb_top
